// *** hw/lcd_defs.vh ***
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH

// ---------------------------------------------------------------------------
// Bus addresses and register offsets
// ---------------------------------------------------------------------------
`define ADDR_BASE_BITS     5'h0f
`define REG_STATUS         8'h00
`define REG_CONFIG         8'h04
`define REG_CONTROL        8'h08
`define REG_MEM_ADDR       8'h0c
`define REG_MEM_DATA       8'h10

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define CTRL_ENABLE_BIT    0
`define CTRL_CLEAR_BIT     1
`define CTRL_RESET         2'h1
`define FILL_CODE          8'h20
`define MEM_DEPTH          128
`define MEM_LAST           7'h7f
`define BUS_WIDTH_RESET    1'b1
`define TWO_LINE_RESET     1'b0
`define FONT_RESET         1'b0
`define DISPLAY_ON_RESET   1'b0
`define CURSOR_ON_RESET    1'b0
`define BLINK_ON_RESET     1'b0
`define ENTRY_INC_RESET    1'b1
`define ENTRY_SHIFT_RESET  1'b0

// ---------------------------------------------------------------------------
// Bit-transfer timing
// ---------------------------------------------------------------------------
`define BITS_PER_BYTE      4'h8

`endif

// *** hw/pin_sync.v ***
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Two-stage synchroniser for the asynchronous pin inputs
// ---------------------------------------------------------------------------
module pin_sync (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire [3:0] pinIn,
    output reg  [3:0] pinOut
);
    reg [3:0] stage1_r;

    // Idle bus lines are pulled high, so the chain resets to high too.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stage1_r <= 4'hf;
            pinOut   <= 4'hf;
        end else begin
            stage1_r <= pinIn;
            pinOut   <= stage1_r;
        end
    end
endmodule

// *** hw/display_mem.v ***
`timescale 1ns/1ps
`include "lcd_defs.vh"

// ---------------------------------------------------------------------------
// Display data memory, one write port and one asynchronous read port
// ---------------------------------------------------------------------------
module display_mem (
    input  wire       clk_sys,
    input  wire       wrEn,
    input  wire [6:0] wrAddr,
    input  wire [7:0] wrData,
    input  wire [6:0] rdAddr,
    output wire [7:0] rdData
);
    reg [7:0] mem [0:`MEM_DEPTH-1];

    // No reset here: contents are set by the fill sequence after reset.
    always @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdData = mem[rdAddr];
endmodule

// *** hw/lcd_i2c_command_receiver.v ***
// What this block does
// - Each eight-bit byte is followed by one acknowledge clock pulse.
// - When addressed as receiver, acknowledge every received byte.
// - Acknowledger holds the data line low through the acknowledge clock high phase.
// - After a master withholds acknowledge, the transmitter releases the data line; this block never transmits.
// - Answer addresses 0111100 to 0111111, low two bits from the straps.
// - Acknowledge only a matching address; otherwise ignore the whole transfer.
// - Only write transfers of commands or display data are accepted.
// - Control byte with continuation flag clear is the last; data bytes follow.
// - Data-select one writes display memory at pointer, pointer advances.
// - Data-select zero decodes bytes as instructions updating configuration.
// - Acknowledge every control byte and every data byte.
// - Stop sending when the master does not acknowledge a sent byte; this block refuses reads and never sends.
// - Initialise itself after reset, busy flag high until done.
// - Initialisation fills every display memory location with 20H.
// - Reset defaults: eight-bit bus width, one line, 5x8 font.
// - Reset defaults: increment address by one, no display shift.
`timescale 1ns/1ps
`include "lcd_defs.vh"

module lcd_i2c_command_receiver (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        sclIn,
    input  wire        sdaIn,
    output reg         sdaOut,
    output reg         sdaOe,
    input  wire        addressStrapLow,
    input  wire        addressStrapHigh,
    output reg         busyFlag,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr
);
    // -----------------------------------------------------------------------
    // States of the serial receiver
    // -----------------------------------------------------------------------
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_CTRL   = 3'h2;
    localparam [2:0] ST_DATA   = 3'h3;
    localparam [2:0] ST_IGNORE = 3'h4;

    reg  [2:0]  state_r;
    reg  [3:0]  bitCnt_r;
    reg  [7:0]  shift_r;
    reg         ackPhase_r;
    reg         sclD_r;
    reg         sdaD_r;
    reg         contFlag_r;
    reg         dataSelectFlag_r;
    reg  [6:0]  pointer_r;
    reg  [6:0]  fillCnt_r;
    reg         busWidthSelect_r;
    reg         twoLine_r;
    reg         font_r;
    reg         displayOn_r;
    reg         cursorOn_r;
    reg         blinkOn_r;
    reg         entryInc_r;
    reg         entryShift_r;
    reg  [1:0]  control_r;
    reg  [6:0]  memRdAddr_r;
    reg  [1:0]  straps_r;
    reg         memWr;
    reg  [6:0]  memWrAddr;
    reg  [7:0]  memWrData;
    wire [3:0]  pinsSync;
    wire [7:0]  memRdData;
    wire        sclS;
    wire        sdaS;
    wire        sclRise;
    wire        sclFall;
    wire        startCond;
    wire        stopCond;
    wire [7:0]  rxByte;
    wire        addrMatch;
    wire        apbAccess;

    // -----------------------------------------------------------------------
    // Pin synchronisers and bus events
    // -----------------------------------------------------------------------
    pin_sync u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pinIn   ({addressStrapHigh, addressStrapLow, sdaIn, sclIn}),
        .pinOut  (pinsSync)
    );

    display_mem u_mem (
        .clk_sys (clk_sys),
        .wrEn    (memWr),
        .wrAddr  (memWrAddr),
        .wrData  (memWrData),
        .rdAddr  (memRdAddr_r),
        .rdData  (memRdData)
    );

    assign sclS      = pinsSync[0];
    assign sdaS      = pinsSync[1];
    assign sclRise   = sclS & ~sclD_r;
    assign sclFall   = ~sclS & sclD_r;
    assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
    assign stopCond  = sclS & sclD_r & ~sdaD_r & sdaS;
    assign rxByte    = shift_r;
    // Straps are read through the synchroniser and compared when the address
    // byte ends, so a change in the middle of that byte counts for that byte.
    assign addrMatch = (rxByte[7:1] == {`ADDR_BASE_BITS, straps_r});

    // Pointer step in the current entry direction, wrapping at both ends.
    function [6:0] stepPtr;
        input [6:0] ptr;
        input       inc;
        begin
            stepPtr = inc ? ptr + 7'h01 : ptr - 7'h01;
        end
    endfunction

    // -----------------------------------------------------------------------
    // Memory write port: the fill sequence owns it while busy
    // -----------------------------------------------------------------------
    always @* begin
        memWr     = 1'b0;
        memWrAddr = pointer_r;
        memWrData = rxByte;
        if (busyFlag) begin
            memWr     = 1'b1;
            memWrAddr = fillCnt_r;
            memWrData = `FILL_CODE;
        end else if (sclFall && ackPhase_r == 1'b0 && bitCnt_r == `BITS_PER_BYTE
                     && state_r == ST_DATA && dataSelectFlag_r) begin
            memWr = 1'b1;
        end
    end

    // -----------------------------------------------------------------------
    // Serial receiver, decode and configuration
    // -----------------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r          <= ST_IDLE;
            bitCnt_r         <= 4'h0;
            shift_r          <= 8'h00;
            ackPhase_r       <= 1'b0;
            sclD_r           <= 1'b1;
            sdaD_r           <= 1'b1;
            sdaOut           <= 1'b0;
            sdaOe            <= 1'b0;
            contFlag_r       <= 1'b0;
            dataSelectFlag_r <= 1'b0;
            pointer_r        <= 7'h00;
            fillCnt_r        <= 7'h00;
            busyFlag         <= 1'b1;
            busWidthSelect_r <= `BUS_WIDTH_RESET;
            twoLine_r        <= `TWO_LINE_RESET;
            font_r           <= `FONT_RESET;
            displayOn_r      <= `DISPLAY_ON_RESET;
            cursorOn_r       <= `CURSOR_ON_RESET;
            blinkOn_r        <= `BLINK_ON_RESET;
            entryInc_r       <= `ENTRY_INC_RESET;
            entryShift_r     <= `ENTRY_SHIFT_RESET;
            straps_r         <= 2'h0;
        end else begin
            sclD_r   <= sclS;
            sdaD_r   <= sdaS;
            straps_r <= pinsSync[3:2];
            if (busyFlag) begin
                fillCnt_r <= fillCnt_r + 7'h01;
                if (fillCnt_r == `MEM_LAST) begin
                    busyFlag <= 1'b0;
                end
            end
            if (startCond) begin
                state_r    <= control_r[`CTRL_ENABLE_BIT] ? ST_ADDR : ST_IGNORE;
                bitCnt_r   <= 4'h0;
                ackPhase_r <= 1'b0;
                sdaOe      <= 1'b0;
            end else if (stopCond) begin
                state_r    <= ST_IDLE;
                bitCnt_r   <= 4'h0;
                ackPhase_r <= 1'b0;
                sdaOe      <= 1'b0;
            end else if (state_r != ST_IDLE) begin
                if (sclRise && !ackPhase_r && bitCnt_r != `BITS_PER_BYTE) begin
                    shift_r  <= {shift_r[6:0], sdaS};
                    bitCnt_r <= bitCnt_r + 4'h1;
                end else if (sclFall && ackPhase_r) begin
                    // The device never transmits, so after the acknowledge
                    // pulse it always lets go of the line.
                    sdaOe      <= 1'b0;
                    ackPhase_r <= 1'b0;
                end else if (sclFall && bitCnt_r == `BITS_PER_BYTE) begin
                    bitCnt_r   <= 4'h0;
                    ackPhase_r <= 1'b1;
                    case (state_r)
                        ST_ADDR: begin
                            // Reads are refused so the device stays receiver only.
                            if (addrMatch && !rxByte[0]) begin
                                state_r <= ST_CTRL;
                                sdaOe   <= 1'b1;
                            end else begin
                                state_r <= ST_IGNORE;
                            end
                        end
                        ST_CTRL: begin
                            contFlag_r       <= rxByte[7];
                            dataSelectFlag_r <= rxByte[6];
                            state_r          <= ST_DATA;
                            sdaOe            <= 1'b1;
                        end
                        ST_DATA: begin
                            sdaOe <= 1'b1;
                            if (contFlag_r) begin
                                state_r <= ST_CTRL;
                            end
                            if (busyFlag) begin
                                // Bytes during the fill are acknowledged but dropped.
                                state_r <= contFlag_r ? ST_CTRL : ST_DATA;
                            end else if (dataSelectFlag_r) begin
                                pointer_r <= stepPtr(pointer_r, entryInc_r);
                            end else if (rxByte[7]) begin
                                pointer_r <= rxByte[6:0];
                            end else if (rxByte[6]) begin
                                pointer_r <= pointer_r;
                            end else if (rxByte[5]) begin
                                busWidthSelect_r <= rxByte[4];
                                twoLine_r        <= rxByte[3];
                                font_r           <= rxByte[2];
                            end else if (rxByte[4]) begin
                                pointer_r <= rxByte[2] ? pointer_r + 7'h01
                                                       : pointer_r - 7'h01;
                            end else if (rxByte[3]) begin
                                displayOn_r <= rxByte[2];
                                cursorOn_r  <= rxByte[1];
                                blinkOn_r   <= rxByte[0];
                            end else if (rxByte[2]) begin
                                entryInc_r   <= rxByte[1];
                                entryShift_r <= rxByte[0];
                            end else if (rxByte[1]) begin
                                pointer_r <= 7'h00;
                            end else if (rxByte[0]) begin
                                pointer_r  <= 7'h00;
                                entryInc_r <= 1'b1;
                                fillCnt_r  <= 7'h00;
                                busyFlag   <= 1'b1;
                            end
                        end
                        default: begin
                            state_r <= ST_IGNORE;
                        end
                    endcase
                end
            end
            if (apbAccess && pwrite && paddr == `REG_CONTROL
                && pwdata[`CTRL_CLEAR_BIT] && !busyFlag) begin
                fillCnt_r <= 7'h00;
                pointer_r <= 7'h00;
                busyFlag  <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------------
    // APB slave, one wait state, registered answer
    // -----------------------------------------------------------------------
    assign apbAccess = psel & penable & ~pready;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            control_r   <= `CTRL_RESET;
            memRdAddr_r <= 7'h00;
        end else begin
            pready  <= apbAccess;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (apbAccess) begin
                case (paddr)
                    `REG_STATUS: begin
                        prdata <= {20'h00000, state_r, pointer_r, 1'b0, busyFlag};
                    end
                    `REG_CONFIG: begin
                        prdata <= {24'h000000, busWidthSelect_r, twoLine_r, font_r,
                                   displayOn_r, cursorOn_r, blinkOn_r,
                                   entryInc_r, entryShift_r};
                    end
                    `REG_CONTROL: begin
                        prdata <= {30'h00000000, 1'b0, control_r[`CTRL_ENABLE_BIT]};
                        if (pwrite) begin
                            control_r <= {1'b0, pwdata[`CTRL_ENABLE_BIT]};
                        end
                    end
                    `REG_MEM_ADDR: begin
                        prdata <= {25'h0000000, memRdAddr_r};
                        if (pwrite) begin
                            memRdAddr_r <= pwdata[6:0];
                        end
                    end
                    `REG_MEM_DATA: begin
                        prdata <= {24'h000000, memRdData};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// *** tb/lcd_i2c_command_receiver_chk.sv ***
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Port checker for the serial command receiver
// ---------------------------------------------------------------------------
module lcd_i2c_command_receiver_chk (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       busyFlag,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    busy_start_a:
        assert property ($rose(rstn) |-> busyFlag [*8]) else $error("busy low after reset");
    busy_end_a:
        assert property ($rose(rstn) |-> ##[100:300] !busyFlag) else $error("busy never ends");
    pull_only_a:
        assert property (sdaOe |-> !sdaOut) else $error("data pin driven high");
    ack_hold_a:
        assert property ($rose(sdaOe) |-> sdaOe [*8]) else $error("acknowledge too short");
    ack_end_a:
        assert property ($rose(sdaOe) |-> ##[20:60] !sdaOe) else $error("acknowledge not released");
    ack_stable_a:
        assert property (sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("drive moved in high");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    ready_answer_a:
        assert property (psel && penable && !pready |=> pready) else $error("ready late");
    err_map_a:
        assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'b00))
            else $error("error flag does not match address map");
    err_qual_a:
        assert property (pslverr |-> pready) else $error("error flag without ready");
endmodule

bind lcd_i2c_command_receiver lcd_i2c_command_receiver_chk chk (
    .clk_sys(clk_sys), .rstn(rstn), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .busyFlag(busyFlag), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr));

// *** tb/i2c_master_model.sv ***
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Two-wire bus master; the clock stands high between frames.
// ---------------------------------------------------------------------------
module i2c_master_model (
    input  wire logic clk_sys,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaPull
);
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic hold(input int n);
        repeat (10 * n) @(posedge clk_sys);
    endtask

    task automatic start();
        sdaPull <= 1'b0;
        hold(1);
        scl <= 1'b1;
        hold(1);
        sdaPull <= 1'b1;
        hold(1);
        scl <= 1'b0;
        hold(1);
    endtask

    task automatic stop();
        sdaPull <= 1'b1;
        hold(1);
        scl <= 1'b1;
        hold(1);
        sdaPull <= 1'b0;
        hold(1);
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic early;
        for (int i = 7; i >= 0; i--) begin
            sdaPull <= ~b[i];
            hold(1);
            scl <= 1'b1;
            hold(2);
            scl <= 1'b0;
            hold(1);
        end
        // Released for the ninth pulse so only the receiver can hold it low.
        sdaPull <= 1'b0;
        hold(1);
        scl <= 1'b1;
        @(posedge clk_sys);
        early = sdaLine;
        repeat (19) @(posedge clk_sys);
        ack = (early === 1'b0) && (sdaLine === 1'b0);
        scl <= 1'b0;
        hold(1);
    endtask
endmodule

// *** tb/lcd_i2c_command_receiver_tb.sv ***
`timescale 1ns/1ps
`include "lcd_defs.vh"

module lcd_i2c_command_receiver_tb;
    logic        clk_sys;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sdaOut;
    logic        sdaOe;
    logic        busyFlag;
    logic [1:0]  strap;
    logic        scl;
    logic        sdaPull;
    wire         sdaLine = !(sdaPull || (sdaOe && sdaOut === 1'b0));
    int          errors;
    int          num_checks;
    logic [7:0]  mem [128];
    logic [7:0]  cfg;
    int          ptr;

    lcd_i2c_command_receiver dut (
        .clk_sys(clk_sys), .rstn(rstn), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapLow(strap[0]),
        .addressStrapHigh(strap[1]), .busyFlag(busyFlag), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    i2c_master_model host (
        .clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));

    // ---------------------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmpAll();
        logic [31:0] r;
        logic        e;
        apb(1'b0, `REG_CONFIG, 32'h0, r, e);
        chk(r, {24'h0, cfg});
        apb(1'b0, `REG_STATUS, 32'h0, r, e);
        chk({25'h0, r[8:2]}, {25'h0, ptr[6:0]});
        for (int i = 0; i < 128; i++) begin
            apb(1'b1, `REG_MEM_ADDR, 32'(i), r, e);
            apb(1'b0, `REG_MEM_DATA, 32'h0, r, e);
            chk(r, {24'h0, mem[i]});
        end
    endtask

    // Reference model of how the bytes after the address are routed.
    task automatic mdl(input logic [7:0] q[$]);
        logic ctl = 1'b1;
        logic cont = 1'b1;
        logic dsel = 1'b0;
        for (int i = 1; i < q.size(); i++) begin
            if (ctl) begin
                cont = q[i][7];
                dsel = q[i][6];
                ctl = 1'b0;
            end else begin
                ctl = cont;
                if (dsel) begin
                    mem[ptr] = q[i];
                    ptr = (ptr + (cfg[1] ? 1 : 127)) % 128;
                end else if (q[i][7]) ptr = q[i][6:0];
                else if (q[i][7:5] == 3'b001) cfg[7:5] = q[i][4:2];
                else if (q[i][7:3] == 5'b00001) cfg[4:2] = q[i][2:0];
                else if (q[i][7:2] == 6'b000001) cfg[1:0] = q[i][1:0];
                else if (q[i][7:4] == 4'b0001) ptr = (ptr + (q[i][2] ? 1 : 127)) % 128;
                else if (q[i] == 8'h02) ptr = 0;
                else if (q[i] == 8'h01) begin
                    ptr = 0;
                    cfg[1] = 1'b1;
                    foreach (mem[j]) mem[j] = `FILL_CODE;
                end
            end
        end
    endtask

    // A refused byte ends the frame: nothing after it would be taken anyway.
    task automatic xfer(input logic [7:0] q[$], input int expAck);
        logic ack;
        int   n = 0;
        host.start();
        foreach (q[i]) begin
            host.sendByte(q[i], ack);
            if (ack !== 1'b1) break;
            n++;
        end
        host.stop();
        chk(n, expAck);
        if (n == q.size()) mdl(q);
    endtask

    // ---------------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ---------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        #300000;
        errors++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  q[$];
        logic [7:0]  d;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        strap = 2'b00;
        cfg = 8'h82;
        ptr = 0;
        foreach (mem[i]) mem[i] = 8'h20;
        void'($urandom(32'h078f));
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk({31'h0, busyFlag}, 32'h1);
        for (int i = 0; i < 400 && busyFlag !== 1'b0; i++) @(posedge clk_sys);
        chk({31'h0, busyFlag}, 32'h0);
        apb(1'b0, `REG_CONTROL, 32'h0, r, e);
        chk({31'h0, r[0]}, 32'h1);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        cmpAll();
        $display("test reset defaults done");
        for (int s = 0; s < 4; s++) begin
            strap <= s[1:0];
            for (int a = 0; a < 4; a++) begin
                q = {8'h78 | 8'(a << 1)};
                xfer(q, int'(a == s));
                q = {8'h79 | 8'(a << 1)};
                xfer(q, 0);
            end
        end
        $display("test address straps done");
        q = {8'h7e, 8'h40};
        repeat (3) q.push_back(8'($urandom));
        xfer(q, 5);
        d = 8'($urandom);
        q = {8'h7e, 8'hc0, d, 8'h80, 8'h85, 8'h40, ~d};
        xfer(q, 7);
        cmpAll();
        $display("test data and continuation done");
        q = {8'h7e, 8'h00, 8'h38, 8'h0f, 8'h04};
        xfer(q, 5);
        q = {8'h7e, 8'h40, 8'($urandom), 8'($urandom)};
        xfer(q, 4);
        cmpAll();
        $display("test instructions done");
        // The clear sits early in the frame so the fill ends before the next byte.
        q = {8'h7e, 8'h00, 8'h14, 8'h14, 8'h01, 8'h10, 8'h02, 8'h14, 8'h40};
        xfer(q, 9);
        cmpAll();
        apb(1'b1, `REG_CONTROL, 32'h0, r, e);
        q = {8'h7e};
        xfer(q, 0);
        apb(1'b1, `REG_CONTROL, 32'h3, r, e);
        chk({31'h0, busyFlag}, 32'h1);
        foreach (mem[i]) mem[i] = `FILL_CODE;
        ptr = 0;
        for (int i = 0; i < 400 && busyFlag !== 1'b0; i++) @(posedge clk_sys);
        chk({31'h0, busyFlag}, 32'h0);
        cmpAll();
        $display("test clear and enable done");
        conclude();
    end
endmodule
